// ===== include/dmic_defs.vh
`ifndef DMIC_DEFS_VH
`define DMIC_DEFS_VH
// address fields of a fetch
`define DMIC_TAG_HI 31
`define DMIC_TAG_LO 12
`define DMIC_IDX_HI 11
`define DMIC_IDX_LO 4
`define DMIC_WRD_HI 11
`define DMIC_WRD_LO 2
`define DMIC_LW_HI 3
`define DMIC_LW_LO 2
`define DMIC_MRU_HI 8
`define DMIC_MRU_LO 4
// geometry
`define DMIC_LINES 256
`define DMIC_WORDS 1024
`define DMIC_TAG_W 20
`define DMIC_LINE_LW 4
// control word field positions
`define DMIC_CTL_EN 31
`define DMIC_CTL_INV 24
`define DMIC_CTL_NCBUF 10
`define DMIC_CTL_LNF_HI 9
`define DMIC_CTL_LNF_LO 8
`define DMIC_CTL_RESET 32'h00000000
// invalidate sweep length in cycles
`define DMIC_INV_CYCLES 9'h100
`endif

// ===== design/dmic_cache.v
// What this block does
// RQ1: direct-mapped cache of 256 lines of 16 bytes, 4 KB in all
// RQ2: 256 tag entries with valid bit, data array 1024 words of 32 bits
// RQ3: tag and data read in parallel, index bits 11:4, word bits 11:2
// RQ4: hit when tag equals bits 31:12 and line valid; data out in one cycle
// RQ5: one valid bit per line, so only whole lines enter the data array
// RQ6: a 16-byte fill buffer holds the last line fetched on a miss
// RQ7: every fetch looks in tag array and fill buffer; either hit is single cycle
// RQ8: fill buffer has a valid bit per longword, arrived words served at once
// RQ9: miss in both starts an external fetch, normally a 16-byte line burst
// RQ10: local bus released after first access while rest of line fills buffer
// RQ11: serve core fetches and debug accesses marked as instruction fetches only
// RQ12: sram-mapped fetch discards cache output and starts no external fetch
// RQ13: invalidate-all clears one tag valid per cycle over 256 cycles, fetches stall
// RQ14: reset clears control, cache disabled, tag contents kept untouched
// RQ15: line fetch starts at critical longword, then wraps upward modulo 16 bytes
// RQ16: buffer written to array on next miss only if full and still most recent
// RQ17: fill buffer keeps its line address and compares it for buffer hits
// RQ18: all state clocked on core clock, hit decided in the fetch cycle
`timescale 1ns/10ps
`default_nettype none
`include "dmic_defs.vh"
module dmic_cache (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire [31:0] CTL_WDATA,
  input wire CTL_WE,
  input wire FETCH_REQ,
  input wire FETCH_IFETCH,
  input wire FETCH_SRAM,
  input wire FETCH_CACHEABLE,
  input wire [31:0] FETCH_ADDR,
  input wire EXT_READY,
  input wire [31:0] EXT_RDATA,
  output reg FETCH_DONE,
  output reg [31:0] FETCH_RDATA,
  output reg FETCH_STALL,
  output reg EXT_REQ,
  output reg [31:0] EXT_ADDR,
  output reg EXT_LINE,
  output reg [31:0] CTL_RDATA
);
  // ****************************************
  // state and storage
  // ****************************************
  localparam ST_IDLE = 3'h1;
  localparam ST_FILL = 3'h2;
  localparam ST_INV = 3'h4;
  reg [2:0] st_r;
  reg [31:0] ctl_r;
  reg [`DMIC_TAG_W-1:0] tag_mem [0:`DMIC_LINES-1]; // RQ2
  reg tag_vld [0:`DMIC_LINES-1]; // RQ5
  reg [31:0] dat_mem [0:`DMIC_WORDS-1]; // RQ1
  reg [31:0] fb_dat_r [0:`DMIC_LINE_LW-1]; // RQ6
  reg [`DMIC_LINE_LW-1:0] fb_vld_r; // RQ8
  reg [27:0] fb_line_r;
  reg fb_cach_r;
  reg fb_mru_r;
  reg [1:0] fill_lw_r;
  reg [1:0] fill_cnt_r;
  reg [27:0] fill_line_r;
  reg fill_is_line_r;
  reg [8:0] inv_cnt_r;
  reg wait_first_r;
  reg inv_pend_r;
  reg lw_only;
  // ****************************************
  // lookup
  // ****************************************
  wire [7:0] idx = FETCH_ADDR[`DMIC_IDX_HI:`DMIC_IDX_LO]; // RQ3
  wire [9:0] widx = FETCH_ADDR[`DMIC_WRD_HI:`DMIC_WRD_LO]; // RQ3
  wire [1:0] lw = FETCH_ADDR[`DMIC_LW_HI:`DMIC_LW_LO];
  wire en = ctl_r[`DMIC_CTL_EN];
  wire ncbuf = ctl_r[`DMIC_CTL_NCBUF];
  wire [1:0] lnf = ctl_r[`DMIC_CTL_LNF_HI:`DMIC_CTL_LNF_LO];
  wire req = FETCH_REQ & FETCH_IFETCH & ~FETCH_SRAM; // RQ11 RQ12
  wire arr_hit = en & FETCH_CACHEABLE & tag_vld[idx] &
                 (tag_mem[idx] == FETCH_ADDR[`DMIC_TAG_HI:`DMIC_TAG_LO]); // RQ4
  wire fb_hit = en & (fb_line_r == FETCH_ADDR[31:4]) & fb_vld_r[lw] &
                (fb_cach_r | ~FETCH_CACHEABLE); // RQ17 RQ8
  wire hit = arr_hit | fb_hit; // RQ7 RQ18
  wire [31:0] arr_data = dat_mem[widx];
  wire [31:0] hit_data = fb_hit ? fb_dat_r[lw] : arr_data;
  wire inv_wr = CTL_WE & CTL_WDATA[`DMIC_CTL_INV];
  wire inv_go = inv_wr | inv_pend_r;
  // fetch size: line when the buffer is in use (use_fb), unless the field (lnf) and the critical longword (lw) select a single longword
  wire use_fb = en & (FETCH_CACHEABLE | ncbuf);
  always @* begin
    case (lnf)
      2'h0: lw_only = (lw == 2'h3);
      2'h1: lw_only = lw[1];
      default: lw_only = 1'b0;
    endcase
  end
  wire line_fetch = use_fb & ~lw_only; // RQ9
  wire fb_full = &fb_vld_r;
  // a missing access in idle matching the buffer's index bits 8:4 makes the array copy the newer one
  wire fb_idx_hit = FETCH_REQ & (FETCH_ADDR[`DMIC_MRU_HI:`DMIC_MRU_LO] ==
                    fb_line_r[`DMIC_MRU_HI-4:`DMIC_MRU_LO-4]);
  // only whole lines reach the array: the tag has one valid bit
  wire retire = fb_full & fb_mru_r & fb_cach_r; // RQ16 RQ5
  wire [7:0] fb_idx = fb_line_r[7:0];
  integer i;
  // ****************************************
  // control word
  // ****************************************
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      // tag valids are left alone; software sweeps before enabling
      ctl_r <= `DMIC_CTL_RESET; // RQ14
      inv_pend_r <= 1'b0;
      CTL_RDATA <= `DMIC_CTL_RESET;
    end else begin
      CTL_RDATA <= ctl_r;
      if (CTL_WE)
        ctl_r <= CTL_WDATA & ~(32'h1 << `DMIC_CTL_INV);
      // a sweep asked for while busy waits until the sequencer is idle
      // set and clear never meet: set only while busy, clear only when idle
      if (inv_wr && st_r != ST_IDLE)
        inv_pend_r <= 1'b1; // RQ13
      else if (st_r == ST_IDLE)
        inv_pend_r <= 1'b0;
    end
  end
  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      fb_vld_r <= 4'h0;
      fb_line_r <= 28'h0000000;
      fb_cach_r <= 1'b0;
      fb_mru_r <= 1'b0;
      fill_lw_r <= 2'h0;
      fill_cnt_r <= 2'h0;
      fill_line_r <= 28'h0000000;
      fill_is_line_r <= 1'b0;
      inv_cnt_r <= 9'h000;
      wait_first_r <= 1'b0;
      FETCH_DONE <= 1'b0;
      FETCH_RDATA <= 32'h00000000;
      FETCH_STALL <= 1'b0;
      EXT_REQ <= 1'b0;
      EXT_ADDR <= 32'h00000000;
      EXT_LINE <= 1'b0;
    end else begin
      FETCH_DONE <= 1'b0;
      if (fb_idx_hit && !hit && st_r == ST_IDLE)
        fb_mru_r <= 1'b0; // RQ16
      case (st_r)
        ST_IDLE: begin
          FETCH_STALL <= 1'b0;
          if (inv_go) begin
            st_r <= ST_INV; // RQ13
            inv_cnt_r <= 9'h000;
            FETCH_STALL <= 1'b1;
          end else if (req && hit) begin
            FETCH_DONE <= 1'b1; // RQ4 RQ7
            FETCH_RDATA <= hit_data;
          end else if (req) begin
            if (retire) begin
              for (i = 0; i < `DMIC_LINE_LW; i = i + 1)
                dat_mem[{fb_idx, i[1:0]}] <= fb_dat_r[i]; // RQ16
              tag_mem[fb_idx] <= fb_line_r[27:8];
              tag_vld[fb_idx] <= 1'b1;
            end
            EXT_REQ <= 1'b1; // RQ9
            EXT_ADDR <= {FETCH_ADDR[31:2], 2'h0};
            EXT_LINE <= line_fetch;
            fill_is_line_r <= line_fetch;
            fill_line_r <= FETCH_ADDR[31:4];
            fill_lw_r <= lw; // RQ15
            fill_cnt_r <= 2'h0;
            wait_first_r <= 1'b1;
            FETCH_STALL <= 1'b1;
            if (line_fetch) begin
              fb_vld_r <= 4'h0;
              fb_line_r <= FETCH_ADDR[31:4];
              fb_cach_r <= FETCH_CACHEABLE;
              fb_mru_r <= FETCH_CACHEABLE;
            end
            st_r <= ST_FILL;
          end
        end
        ST_FILL: begin
          // later hits are served only once the stalled miss has its word
          if (req && hit && !wait_first_r) begin
            FETCH_DONE <= 1'b1; // RQ10
            FETCH_RDATA <= hit_data;
          end
          if (EXT_READY) begin
            EXT_REQ <= 1'b0;
            if (fill_is_line_r) begin
              fb_dat_r[fill_lw_r] <= EXT_RDATA;
              fb_vld_r[fill_lw_r] <= 1'b1;
            end
            if (wait_first_r) begin
              FETCH_DONE <= 1'b1;
              FETCH_RDATA <= EXT_RDATA;
              FETCH_STALL <= 1'b0; // RQ10
              wait_first_r <= 1'b0;
            end
            fill_lw_r <= fill_lw_r + 2'h1; // RQ15
            fill_cnt_r <= fill_cnt_r + 2'h1;
            EXT_ADDR <= {fill_line_r, fill_lw_r + 2'h1, 2'h0};
            if (!fill_is_line_r || fill_cnt_r == 2'h3)
              st_r <= ST_IDLE;
          end
        end
        ST_INV: begin
          // one tag valid per cycle; fetches wait on the stall
          tag_vld[inv_cnt_r[7:0]] <= 1'b0; // RQ13
          inv_cnt_r <= inv_cnt_r + 9'h001;
          if (inv_cnt_r == `DMIC_INV_CYCLES - 9'h001) begin
            st_r <= ST_IDLE;
            FETCH_STALL <= 1'b0;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // dmic_cache
`default_nettype wire

// ===== bench/dmic_cache_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dmic_cache_sva (
  input wire CORE_CLK, SYS_RST, CTL_WE, FETCH_REQ, FETCH_IFETCH, FETCH_SRAM, EXT_READY,
  input wire FETCH_DONE, FETCH_STALL, EXT_REQ, EXT_LINE,
  input wire [31:0] CTL_WDATA, FETCH_ADDR, EXT_RDATA, FETCH_RDATA, EXT_ADDR, CTL_RDATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_first; EXT_REQ && EXT_READY; endsequence
  sequence s_free; FETCH_DONE && !FETCH_STALL && !EXT_REQ; endsequence
  a_reset_clears: assert property (disable iff (1'h0) SYS_RST |=> !FETCH_DONE && !EXT_REQ && CTL_RDATA == 32'h0)
    else $error("reset value");
  a_inv_stall: assert property (CTL_WE && CTL_WDATA[24] && !FETCH_STALL && !EXT_REQ |=> FETCH_STALL [*8])
    else $error("no sweep stall");
  a_sweep_quiet: assert property (FETCH_STALL && !EXT_REQ |=> !FETCH_DONE)
    else $error("fetch during sweep");
  a_crit_first: assert property ($rose(EXT_REQ) |-> FETCH_STALL && EXT_ADDR == {$past(FETCH_ADDR[31:2]), 2'h0})
    else $error("critical word");
  a_req_holds: assert property (EXT_REQ && !EXT_READY |=> EXT_REQ && $stable(EXT_ADDR))
    else $error("request dropped");
  a_first_release: assert property (s_first |=> s_free ##0 FETCH_RDATA == $past(EXT_RDATA))
    else $error("bus not released");
  a_line_wraps: assert property ((s_first and EXT_LINE) |=> EXT_ADDR[3:2] == $past(EXT_ADDR[3:2]) + 2'h1)
    else $error("wrap order");
  a_skip_ignored: assert property (FETCH_REQ && (FETCH_SRAM || !FETCH_IFETCH) && !FETCH_STALL && !EXT_REQ
    |=> !EXT_REQ && !FETCH_DONE)
    else $error("fetch not ignored");
endmodule // dmic_cache_sva
bind dmic_cache dmic_cache_sva u_sva (.*);
`default_nettype wire

// ===== bench/dmic_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmic_ext_model (
  input wire logic clk, rst, req, line,
  input wire logic [31:0] addr,
  input wire logic [1:0] lat,
  output logic rdy,
  output logic [31:0] rdata
);
  logic [2:0] n_r;
  logic [1:0] w_r;
  logic [31:0] a_r;
  // idle data toggles every cycle so stale values never match
  always @(posedge clk) begin
    rdy <= 1'h0;
    rdata <= ~rdata;
    if (rst) begin
      n_r <= 3'h0;
      rdata <= 32'h0;
    end else if (n_r == 3'h0) begin
      if (req && !rdy) begin
        n_r <= line ? 3'h4 : 3'h1;
        w_r <= lat;
        a_r <= addr;
      end
    end else if (w_r != 2'h0) begin
      w_r <= w_r - 2'h1;
    end else begin
      rdy <= 1'h1;
      // the far side walks the line itself, wrapping from the critical word
      rdata <= a_r ^ 32'h5A5A0000;
      a_r[3:2] <= a_r[3:2] + 2'h1;
      n_r <= n_r - 3'h1;
      w_r <= lat;
    end
  end
endmodule // dmic_ext_model
`default_nettype wire

// ===== bench/dmic_cache_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dmic_cache_tb;
  logic clk = 1'h0, rst = 1'h1, we = 1'h0, req = 1'h0, ifet = 1'h1, sram = 1'h0, cach = 1'h1;
  logic rdy, done, stall, xreq, line;
  logic [31:0] wd = 32'h0, addr = 32'h0, erd, rd, ea, crd;
  logic [1:0] lat = 2'h0;
  logic [31:0] q[$];
  int n_mismatch = 0, samples_checked = 0, cyc = 0, cnt;
  dmic_cache u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CTL_WDATA(wd), .CTL_WE(we), .FETCH_REQ(req),
    .FETCH_IFETCH(ifet), .FETCH_SRAM(sram), .FETCH_CACHEABLE(cach), .FETCH_ADDR(addr), .EXT_READY(rdy),
    .EXT_RDATA(erd), .FETCH_DONE(done), .FETCH_RDATA(rd), .FETCH_STALL(stall), .EXT_REQ(xreq),
    .EXT_ADDR(ea), .EXT_LINE(line), .CTL_RDATA(crd));
  dmic_ext_model u_ext (.clk(clk), .rst(rst), .req(xreq), .line(line), .addr(ea), .lat(lat), .rdy(rdy), .rdata(erd));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rdy) q.push_back(ea);
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task fe(input logic [31:0] a);
    @(negedge clk) addr = a;
    req = 1'h1;
    for (cnt = 0; cnt < 40 && done !== 1'h1; cnt++) @(negedge clk);
    chk(done, 1);
    chk(rd, {a[31:2], 2'h0} ^ 32'h5A5A0000);
    req = 1'h0;
    repeat (2) @(negedge clk);
  endtask
  task ctl(input logic [31:0] v);
    @(negedge clk) wd = v;
    we = 1'h1;
    @(negedge clk) we = 1'h0;
  endtask
  task t_inv;
    ctl(32'h01000000);
    cnt = stall;
    repeat (300) @(negedge clk) if (stall) cnt++;
    chk(cnt, 256);
    ctl(32'h80000200);
  endtask
  task t_miss;
    q.delete();
    fe(32'h00001008);
    repeat (8) @(negedge clk);
    chk(q.size(), 4);
    foreach (q[i]) chk(q[i], 32'h00001000 + ((32'h8 + 4 * i) & 32'hC));
    fe(32'h00001004);
    chk(cnt, 1);
    chk(q.size(), 4);
  endtask
  task t_fill;
    lat = 2'h3;
    fe(32'h0000210C);
    fe(32'h0000210C);
    chk(q.size() < 8, 1);
    repeat (20) @(negedge clk);
    lat = 2'h0;
  endtask
  task t_array;
    fe(32'h00003040);
    repeat (8) @(negedge clk);
    q.delete();
    fe(32'h00001000);
    chk(cnt, 1);
    fe(32'h00002100);
    chk(q.size(), 0);
  endtask
  task t_lword;
    ctl(32'h80000000);
    q.delete();
    fe(32'h0000400C);
    cach = 1'h0;
    fe(32'h00005000);
    cach = 1'h1;
    repeat (4) @(negedge clk);
    chk(q.size(), 2);
    chk(q[1], 32'h00005000);
    ctl(32'h80000200);
  endtask
  task t_skip(input logic s, i);
    @(negedge clk) sram = s;
    ifet = i;
    addr = 32'h00007000;
    req = 1'h1;
    cnt = 0;
    repeat (6) @(negedge clk) if (done || xreq) cnt++;
    req = 1'h0;
    sram = 1'h0;
    ifet = 1'h1;
    chk(cnt, 0);
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'h0;
    chk(done, 32'h0);
    chk(xreq, 32'h0);
    chk(stall, 32'h0);
    chk(crd, 32'h0);
    t_inv();
    t_miss();
    t_fill();
    t_array();
    t_lword();
    t_skip(1'h1, 1'h1);
    t_skip(1'h0, 1'h0);
    print_verdict();
  end
endmodule // dmic_cache_tb
`default_nettype wire
